// *** logic/sync_out_pkg.sv ***
package sync_out_pkg;
  // ***************************************************************
  // register map (byte addresses on the AXI4-Lite slave)
  // ***************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HSYNC_W = 8'h04;
  localparam logic [7:0] ADDR_VSYNC_W = 8'h08;
  localparam logic [7:0] ADDR_LINE_LEN = 8'h0C;
  localparam logic [7:0] ADDR_FRAME_LEN = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // ***************************************************************
  // field positions and reset values
  // ***************************************************************
  localparam int CTRL_CSYNC_BIT = 7;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] HSYNC_W_RST = 8'h08;
  localparam logic [7:0] VSYNC_W_RST = 8'h02;
  localparam logic [10:0] LINE_LEN_RST = 11'h0FF;
  localparam logic [10:0] FRAME_LEN_RST = 11'h0FF;
  localparam int PAL_SUP_BIT = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** logic/sync_pixel_stage.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync_pixel_stage (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pix_en,
  input wire logic [12:0] pix_colour,
  input wire logic pix_sup_valid,
  output logic mixer_priority_out_n,
  output logic [3:0] red_nibble_ext_out
);
  // ***************************************************************
  // registered per-pixel outputs
  // ***************************************************************
  logic sup_ff;
  logic [3:0] red_ff;

  // supremacy taken from bit 12 of the pixel's colour, masked by pix_sup_valid, each pixel
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sup_ff <= 1'b1;
    end else if (pix_en) begin
      sup_ff <= ~(pix_sup_valid & pix_colour[sync_out_pkg::PAL_SUP_BIT]);
    end
  end

  // inverted red nibble, same pixel alignment
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      red_ff <= 4'hF;
    end else if (pix_en) begin
      red_ff <= ~pix_colour[3:0];
    end
  end

  assign mixer_priority_out_n = sup_ff;
  assign red_nibble_ext_out = red_ff;

  property p_sup_follows;
    @(posedge sys_clk) disable iff (!rst_n)
      pix_en |=> mixer_priority_out_n == ~($past(pix_sup_valid) & $past(pix_colour[12]));
  endproperty
  a_sup_follows: assert property (p_sup_follows) else $error("supremacy output wrong");

  property p_red_inv;
    @(posedge sys_clk) disable iff (!rst_n)
      pix_en |=> red_nibble_ext_out == ~$past(pix_colour[3:0]);
  endproperty
  a_red_inv: assert property (p_red_inv) else $error("red nibble not inverted");

  property p_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      !pix_en |=> $stable(red_nibble_ext_out) && $stable(mixer_priority_out_n);
  endproperty
  a_hold: assert property (p_hold) else $error("pixel outputs moved off pixel edge");

  property p_cov_sup;
    @(posedge sys_clk) disable iff (!rst_n) !mixer_priority_out_n;
  endproperty
  c_cov_sup: cover property (p_cov_sup);
endmodule
`default_nettype wire

// *** logic/video_sync_supremacy_outputs.sv ***
`timescale 1ns/1ps
`default_nettype none
module video_sync_supremacy_outputs (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic pix_en,
  input wire logic [12:0] pix_colour,
  input wire logic pix_sup_valid,
  input wire logic req_pulse,
  output logic req_is_video,
  output logic line_sync_n,
  output logic frame_sync_n,
  output logic mixer_priority_out_n,
  output logic [3:0] red_nibble_ext_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ***************************************************************
  // reset release
  // ***************************************************************
  logic rst_meta_ff;
  logic rst_n;

  // two-stage release of the async reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n <= rst_meta_ff;
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  logic [7:0] ctrl_ff;
  logic [7:0] hsync_w_ff;
  logic [7:0] vsync_w_ff;
  logic [10:0] line_len_ff;
  logic [10:0] frame_len_ff;
  logic aw_ff;
  logic w_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_go;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == sync_out_pkg::ADDR_CTRL) || (a == sync_out_pkg::ADDR_HSYNC_W) ||
                 (a == sync_out_pkg::ADDR_VSYNC_W) || (a == sync_out_pkg::ADDR_LINE_LEN) ||
                 (a == sync_out_pkg::ADDR_FRAME_LEN) || (a == sync_out_pkg::ADDR_STATUS);
  endfunction

  assign s_axi_awready = !aw_ff && !bvalid_ff;
  assign s_axi_wready = !w_ff && !bvalid_ff;
  assign wr_go = aw_ff && w_ff && !bvalid_ff;

  // capture address and data in either order
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[7:2], 2'h0};
      end else if (wr_go) begin
        aw_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_go) begin
        w_ff <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= sync_out_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= addr_known(awaddr_ff) ? sync_out_pkg::RESP_OKAY : sync_out_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // register updates, low lanes only carry data
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= sync_out_pkg::CTRL_RST;
      hsync_w_ff <= sync_out_pkg::HSYNC_W_RST;
      vsync_w_ff <= sync_out_pkg::VSYNC_W_RST;
      line_len_ff <= sync_out_pkg::LINE_LEN_RST;
      frame_len_ff <= sync_out_pkg::FRAME_LEN_RST;
    end else if (wr_go) begin
      case (awaddr_ff)
        sync_out_pkg::ADDR_CTRL: if (wstrb_ff[0]) ctrl_ff <= wdata_ff[7:0];
        sync_out_pkg::ADDR_HSYNC_W: if (wstrb_ff[0]) hsync_w_ff <= wdata_ff[7:0];
        sync_out_pkg::ADDR_VSYNC_W: if (wstrb_ff[0]) vsync_w_ff <= wdata_ff[7:0];
        sync_out_pkg::ADDR_LINE_LEN: begin
          if (wstrb_ff[0]) line_len_ff[7:0] <= wdata_ff[7:0];
          if (wstrb_ff[1]) line_len_ff[10:8] <= wdata_ff[10:8];
        end
        sync_out_pkg::ADDR_FRAME_LEN: begin
          if (wstrb_ff[0]) frame_len_ff[7:0] <= wdata_ff[7:0];
          if (wstrb_ff[1]) frame_len_ff[10:8] <= wdata_ff[10:8];
        end
        default: ;
      endcase
    end
  end

  // ***************************************************************
  // raster timing
  // ***************************************************************
  logic [10:0] hcnt_ff;
  logic [10:0] vcnt_ff;
  logic hs_ff;
  logic vs_ff;
  logic vcs_ff;
  logic line_end;
  logic en;

  assign en = ctrl_ff[sync_out_pkg::CTRL_EN_BIT];
  assign line_end = hcnt_ff >= line_len_ff;

  // horizontal counter advances per pixel, vertical counter once per line
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hcnt_ff <= 11'h000;
      vcnt_ff <= 11'h000;
    end else if (!en) begin
      hcnt_ff <= 11'h000;
      vcnt_ff <= 11'h000;
    end else if (pix_en) begin
      if (line_end) begin
        hcnt_ff <= 11'h000;
        vcnt_ff <= (vcnt_ff >= frame_len_ff) ? 11'h000 : vcnt_ff + 11'h001;
      end else begin
        hcnt_ff <= hcnt_ff + 11'h001;
      end
    end
  end

  // sync outputs registered on every clock edge, not gated by pix_en
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_ff <= 1'b1;
      vs_ff <= 1'b1;
      vcs_ff <= 1'b1;
    end else begin
      hs_ff <= !(en && (hcnt_ff < {2'h0, hsync_w_ff, 1'b0}));
      vs_ff <= !(en && (vcnt_ff < {3'h0, vsync_w_ff}));
      if (ctrl_ff[sync_out_pkg::CTRL_CSYNC_BIT]) begin
        vcs_ff <= ~(hs_ff ^ vs_ff);
      end else begin
        vcs_ff <= vs_ff;
      end
    end
  end

  assign line_sync_n = hs_ff;
  assign frame_sync_n = vcs_ff;

  // request class latched from line sync level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_is_video <= 1'b1;
    end else if (req_pulse) begin
      req_is_video <= hs_ff;
    end
  end

  // ***************************************************************
  // read channel
  // ***************************************************************
  assign s_axi_arready = !rvalid_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= sync_out_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= addr_known({s_axi_araddr[7:2], 2'h0}) ? sync_out_pkg::RESP_OKAY : sync_out_pkg::RESP_SLVERR;
      case ({s_axi_araddr[7:2], 2'h0})
        sync_out_pkg::ADDR_CTRL: rdata_ff <= {24'h000000, ctrl_ff};
        sync_out_pkg::ADDR_HSYNC_W: rdata_ff <= {24'h000000, hsync_w_ff};
        sync_out_pkg::ADDR_VSYNC_W: rdata_ff <= {24'h000000, vsync_w_ff};
        sync_out_pkg::ADDR_LINE_LEN: rdata_ff <= {21'h0, line_len_ff};
        sync_out_pkg::ADDR_FRAME_LEN: rdata_ff <= {21'h0, frame_len_ff};
        // status: [0] line sync, [1] shared sync, [12:2] hcnt, [24:14] vcnt
        sync_out_pkg::ADDR_STATUS: rdata_ff <= {7'h00, vcnt_ff, 1'b0, hcnt_ff, vcs_ff, hs_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  sync_pixel_stage u_pix (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pix_en(pix_en),
    .pix_colour(pix_colour),
    .pix_sup_valid(pix_sup_valid),
    .mixer_priority_out_n(mixer_priority_out_n),
    .red_nibble_ext_out(red_nibble_ext_out)
  );

  // ***************************************************************
  // checks
  // ***************************************************************
  property p_csync;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_ff[7] && $past(ctrl_ff[7]) |-> frame_sync_n == ~($past(hs_ff) ^ $past(vs_ff));
  endproperty
  a_csync: assert property (p_csync) else $error("composite sync not xnor");

  property p_vsel;
    @(posedge sys_clk) disable iff (!rst_n)
      !ctrl_ff[7] && !$past(ctrl_ff[7]) |-> frame_sync_n == $past(vs_ff);
  endproperty
  a_vsel: assert property (p_vsel) else $error("frame sync not routed");

  property p_hs_width;
    @(posedge sys_clk) disable iff (!rst_n)
      $past(en) && ($past(hcnt_ff) < {2'h0, $past(hsync_w_ff), 1'b0}) |-> !line_sync_n;
  endproperty
  a_hs_width: assert property (p_hs_width) else $error("line sync width wrong");

  property p_vs_width;
    @(posedge sys_clk) disable iff (!rst_n)
      $past(en) && ($past(vcnt_ff) >= {3'h0, $past(vsync_w_ff)}) |-> vs_ff;
  endproperty
  a_vs_width: assert property (p_vs_width) else $error("frame sync too long");

  property p_req;
    @(posedge sys_clk) disable iff (!rst_n)
      req_pulse |=> req_is_video == $past(line_sync_n);
  endproperty
  a_req: assert property (p_req) else $error("request class wrong");

  property p_cov_cs;
    @(posedge sys_clk) disable iff (!rst_n) ctrl_ff[7] && !line_sync_n;
  endproperty
  c_cov_cs: cover property (p_cov_cs);

  property p_cov_line;
    @(posedge sys_clk) disable iff (!rst_n) pix_en && line_end && en;
  endproperty
  c_cov_line: cover property (p_cov_line);

  property p_cov_cursor;
    @(posedge sys_clk) disable iff (!rst_n) req_pulse && !line_sync_n;
  endproperty
  c_cov_cursor: cover property (p_cov_cursor);
endmodule
`default_nettype wire

// *** dv/mem_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// memory controller side: raises block requests, notes the class it expects
module mem_ctrl_model (
  input wire logic sys_clk,
  input wire logic req_go,
  input wire logic line_sync_n,
  output logic req_pulse,
  output logic chk_req,
  output logic exp_video
);
  initial begin
    req_pulse = 1'b0;
    chk_req = 1'b0;
    exp_video = 1'b0;
  end
  // line sync level at the request edge tells video from cursor
  always @(posedge sys_clk) begin
    req_pulse <= req_go;
    chk_req <= req_pulse;
    if (req_pulse) begin
      exp_video <= line_sync_n;
    end
  end
endmodule
`default_nettype wire

// *** dv/video_sync_supremacy_outputs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module video_sync_supremacy_outputs_tb;
  // ***********************************************
  // signals
  // ***********************************************
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic pix_en = 1'b0;
  logic [12:0] pix_colour = 13'h0000;
  logic pix_sup_valid = 1'b0;
  logic req_pulse, req_is_video, line_sync_n, frame_sync_n, mixer_priority_out_n;
  logic [3:0] red_nibble_ext_out;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic req_go = 1'b0, chk_req, exp_video, took = 1'b0, pix_run = 1'b0, pix_all = 1'b0;
  logic [31:0] rnd = 32'h29F0;
  logic [4:0] q_pix[$];
  logic [33:0] q_rd[$];
  logic [1:0] q_wr[$];
  logic [4:0] e_pix;
  logic [33:0] e_rd;
  logic [1:0] e_wr;
  int w_tab[3] = '{1, 3, 7};
  int v_tab[3] = '{1, 2, 9};
  int n_fail = 0;
  int compares = 0;

  always #25 sys_clk = ~sys_clk;

  video_sync_supremacy_outputs i_dut (.sys_clk, .resetn, .pix_en, .pix_colour, .pix_sup_valid,
    .req_pulse, .req_is_video, .line_sync_n, .frame_sync_n, .mixer_priority_out_n,
    .red_nibble_ext_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  mem_ctrl_model i_mem (.sys_clk, .req_go, .line_sync_n, .req_pulse, .chk_req, .exp_video);

  // ***********************************************
  // helpers
  // ***********************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // write: both channels offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    q_wr.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    // one idle edge so the next call does not re-raise bready in this step
    @(posedge sys_clk);
  endtask

  // read: expectation noted first, the monitor compares on the answer
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    q_rd.push_back({er, ed});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // counts low cycles of both syncs and composite departures over one frame
  task automatic measure(output int ls, output int fs, output int df);
    logic prev;
    ls = 0;
    fs = 0;
    df = 0;
    @(negedge sys_clk);
    prev = line_sync_n;
    repeat (160) begin
      @(negedge sys_clk);
      ls += (line_sync_n === 1'b0);
      fs += (frame_sync_n === 1'b0);
      df += (frame_sync_n !== prev);
      prev = line_sync_n;
    end
  endtask

  // ***********************************************
  // drivers and monitors
  // ***********************************************
  // random pixels and requests, expectation noted per accepted pixel
  always @(posedge sys_clk) begin
    rnd = lfsr(rnd);
    pix_en <= pix_run & (pix_all | rnd[0]);
    pix_colour <= rnd[13:1];
    pix_sup_valid <= rnd[14];
    req_go <= pix_run & rnd[15] & rnd[16];
    if (pix_run && (pix_all || rnd[0])) begin
      q_pix.push_back({!(rnd[14] & rnd[13]), ~rnd[4:1]});
    end
    took <= pix_en;
  end

  // pixel and request results, settled at the falling edge
  always @(negedge sys_clk) begin
    if (took) begin
      e_pix = q_pix.pop_front();
      chk({27'h0, mixer_priority_out_n, red_nibble_ext_out}, {27'h0, e_pix});
    end
    if (chk_req === 1'b1) begin
      chk({31'h0, req_is_video}, {31'h0, exp_video});
    end
  end

  // read data and write responses checked at the answering edge
  always @(posedge sys_clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      e_rd = q_rd.pop_front();
      chk(s_axi_rdata, e_rd[31:0]);
      chk({30'h0, s_axi_rresp}, {30'h0, e_rd[33:32]});
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      e_wr = q_wr.pop_front();
      chk({30'h0, s_axi_bresp}, {30'h0, e_wr});
    end
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end

  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    int ls, fs, df;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    axi_wr(sync_out_pkg::ADDR_LINE_LEN, 32'h0000_000F, sync_out_pkg::RESP_OKAY);
    axi_wr(sync_out_pkg::ADDR_FRAME_LEN, 32'h0000_0009, sync_out_pkg::RESP_OKAY);
    axi_rd(sync_out_pkg::ADDR_CTRL, 32'h0000_0000, sync_out_pkg::RESP_OKAY);
    axi_rd(sync_out_pkg::ADDR_HSYNC_W, 32'h0000_0008, sync_out_pkg::RESP_OKAY);
    axi_rd(sync_out_pkg::ADDR_VSYNC_W, 32'h0000_0002, sync_out_pkg::RESP_OKAY);
    axi_rd(sync_out_pkg::ADDR_LINE_LEN, 32'h0000_000F, sync_out_pkg::RESP_OKAY);
    axi_rd(sync_out_pkg::ADDR_FRAME_LEN, 32'h0000_0009, sync_out_pkg::RESP_OKAY);
    // disabled raster: counters at zero, both syncs idle high
    axi_rd(sync_out_pkg::ADDR_STATUS, 32'h0000_0003, sync_out_pkg::RESP_OKAY);
    axi_rd(8'h18, 32'h0000_0000, sync_out_pkg::RESP_SLVERR);
    axi_wr(8'h1C, 32'h0000_00FF, sync_out_pkg::RESP_SLVERR);
    pix_all <= 1'b1;
    pix_run <= 1'b1;
    measure(ls, fs, df);
    chk(ls + fs, 0);
    for (int i = 0; i < 3; i++) begin
      for (int m = 0; m < 2; m++) begin
        axi_wr(sync_out_pkg::ADDR_HSYNC_W, 32'(w_tab[i]), sync_out_pkg::RESP_OKAY);
        axi_wr(sync_out_pkg::ADDR_VSYNC_W, 32'(v_tab[i]), sync_out_pkg::RESP_OKAY);
        axi_wr(sync_out_pkg::ADDR_CTRL, (32'(m) << sync_out_pkg::CTRL_CSYNC_BIT) | 32'h1,
          sync_out_pkg::RESP_OKAY);
        repeat (320) @(posedge sys_clk);
        measure(ls, fs, df);
        chk(ls, 20 * w_tab[i]);
        if (m == 0) begin
          chk(fs, 16 * v_tab[i]);
        end else begin
          chk(df, 16 * v_tab[i]);
        end
      end
    end
    pix_all <= 1'b0;
    repeat (300) @(posedge sys_clk);
    pix_run <= 1'b0;
    repeat (3) @(posedge sys_clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
